// [rtl/rsi_defines.vh]
// Constants for the reset state initializer: register map, reset loads, vectors
`ifndef RSI_DEFINES_VH
`define RSI_DEFINES_VH

`define RSI_AW             4
`define RSI_DW             8
`define RSI_PCW            13
`define RSI_EVW            6

`define RSI_OFF_STATUS     4'h0
`define RSI_OFF_PWR_CAUSE  4'h1
`define RSI_OFF_IRQ_CTL    4'h2
`define RSI_OFF_PFLAG_A    4'h3
`define RSI_OFF_PFLAG_B    4'h4
`define RSI_OFF_OPTION     4'h5
`define RSI_OFF_DIR_A      4'h6
`define RSI_OFF_PERIOD_B   4'h7
`define RSI_OFF_HOLD       4'h8
`define RSI_OFF_EV_STAT    4'h9
`define RSI_OFF_EV_MASK    4'hA

`define RSI_IMPL_FULL      8'hFF
`define RSI_IMPL_PFLAG_B   8'h01
`define RSI_IMPL_DIR_A     8'h3F
`define RSI_IMPL_PWR_CAUSE 8'h03
`define RSI_IMPL_EV        8'h3F
`define RSI_ZERO           8'h00
`define RSI_ONES           8'hFF

`define RSI_ST_WMASK       8'hE7
`define RSI_ST_POR_VAL     8'h18
`define RSI_ST_POR_MSK     8'hF8
`define RSI_ST_MASTER_CLEAR_PIN_VAL    8'h00
`define RSI_ST_MASTER_CLEAR_PIN_MSK    8'hE0
`define RSI_ST_MSLP_VAL    8'h10
`define RSI_ST_WDT_VAL     8'h08
`define RSI_ST_WAKE_MSK    8'h18
`define RSI_ST_WWAKE_VAL   8'h00
`define RSI_ST_IWAKE_VAL   8'h10

`define RSI_IC_RST_MSK     8'hFE
`define RSI_PC_POR_MSK     8'h02
`define RSI_PC_BOR_MSK     8'h01

`define RSI_GIE_BIT        7

`define RSI_PC_RESET       13'h0000
`define RSI_PC_VECTOR      13'h0004
`define RSI_PC_STEP        13'h0001

`define RSI_EV_POR         0
`define RSI_EV_BOR         1
`define RSI_EV_MASTER_CLEAR_PIN        2
`define RSI_EV_WDT_RST     3
`define RSI_EV_WDT_WAKE    4
`define RSI_EV_IRQ_WAKE    5

`endif

// [rtl/rsi_sfr.v]
// One special function register with class load, software write and hardware set
`timescale 1ns/1ps
`include "rsi_defines.vh"
module rsi_sfr #(
  parameter [7:0] INIT  = 8'h00,
  parameter [7:0] IMPL  = 8'hFF,
  parameter [7:0] WMASK = 8'hFF
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       load,
  input  wire [7:0] load_val,
  input  wire [7:0] load_mask,
  input  wire       wr,
  input  wire [7:0] wdata,
  input  wire [7:0] set_bits,
  output wire [7:0] q
);

  reg [7:0] val_ff;
  reg [7:0] nxt_val;

  always @* begin
    nxt_val = val_ff;
    if (load) begin
      // Masked-out bits keep their prior value
      nxt_val = (val_ff & ~load_mask) | (load_val & load_mask);
    end else if (wr) begin
      nxt_val = (val_ff & ~WMASK) | (wdata & WMASK);
    end
    // Hardware set wins over a same-cycle write or load
    nxt_val = (nxt_val | set_bits) & IMPL;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      val_ff <= INIT & IMPL;
    end else begin
      val_ff <= nxt_val;
    end
  end

  assign q = val_ff & IMPL;

endmodule

// [rtl/rsi_sync2.v]
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module rsi_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// [rtl/rsi_top.v]
// Reset state initializer: per-class register loads, program counter placement, cause flags
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "rsi_defines.vh"
module rsi_top (
  input  wire                  clk,
  input  wire                  reset_n,
  input  wire                  por_pulse,
  input  wire                  brownout_pulse,
  input  wire                  master_clear_pin_n,
  input  wire                  watchdog_timer_timeout,
  input  wire                  wake_irq,
  input  wire                  core_sleeping,
  input  wire [`RSI_PCW-1:0]   core_pc,
  input  wire [`RSI_DW-1:0]    wake_src_ctl,
  input  wire [`RSI_DW-1:0]    wake_src_a,
  input  wire [`RSI_DW-1:0]    wake_src_b,
  input  wire [`RSI_AW-1:0]    addr,
  input  wire [`RSI_DW-1:0]    wdata,
  input  wire                  wr,
  input  wire                  rd,
  output reg  [`RSI_DW-1:0]    rdata_ff,
  output reg                   irq_ff,
  output reg                   pc_load_ff,
  output reg  [`RSI_PCW-1:0]   pc_value_ff,
  output reg  [`RSI_EVW-1:0]   class_ff
);

  // Source synchronisation and edge detection
  wire [4:0] src_raw;
  wire [4:0] src_sync;
  reg  [4:0] src_prev_ff;
  wire [4:0] src_rise;

  assign src_raw = {wake_irq, watchdog_timer_timeout, ~master_clear_pin_n,
                    brownout_pulse, por_pulse};

  rsi_sync2 #(
    .W (5)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (src_raw),
    .dout    (src_sync)
  );

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_prev_ff <= 5'h00;
    end else begin
      src_prev_ff <= src_sync;
    end
  end

  assign src_rise = src_sync & ~src_prev_ff;

  // Reset class decode, highest priority first
  reg cls_por;
  reg cls_bor;
  reg cls_master_clear_pin;
  reg cls_master_clear_pin_sleep;
  reg cls_wdt_rst;
  reg cls_wdt_wake;
  reg cls_irq_wake;
  reg any_rst;
  reg any_wake;

  always @* begin
    cls_por        = src_rise[0];
    cls_bor        = src_rise[1] & ~cls_por;
    cls_master_clear_pin       = src_rise[2] & ~cls_por & ~cls_bor;
    cls_master_clear_pin_sleep = cls_master_clear_pin & core_sleeping;
    cls_wdt_rst    = src_rise[3] & ~cls_por & ~cls_bor & ~cls_master_clear_pin & ~core_sleeping;
    cls_wdt_wake   = src_rise[3] & ~cls_por & ~cls_bor & ~cls_master_clear_pin & core_sleeping;
    cls_irq_wake   = src_rise[4] & core_sleeping & ~cls_por & ~cls_bor & ~cls_master_clear_pin &
                     ~src_rise[3];
    any_rst        = cls_por | cls_bor | cls_master_clear_pin | cls_wdt_rst;
    any_wake       = cls_wdt_wake | cls_irq_wake;
  end

  // Status register load per class
  reg [7:0] st_val;
  reg [7:0] st_msk;

  always @* begin
    st_val = `RSI_ZERO;
    st_msk = `RSI_ZERO;
    if (cls_por | cls_bor) begin
      st_val = `RSI_ST_POR_VAL;
      st_msk = `RSI_ST_POR_MSK;
    end else if (cls_master_clear_pin_sleep) begin
      st_val = `RSI_ST_MSLP_VAL;
      st_msk = `RSI_ST_POR_MSK;
    end else if (cls_master_clear_pin) begin
      st_val = `RSI_ST_MASTER_CLEAR_PIN_VAL;
      st_msk = `RSI_ST_MASTER_CLEAR_PIN_MSK;
    end else if (cls_wdt_rst) begin
      st_val = `RSI_ST_WDT_VAL;
      st_msk = `RSI_ST_POR_MSK;
    end else if (cls_wdt_wake) begin
      st_val = `RSI_ST_WWAKE_VAL;
      st_msk = `RSI_ST_WAKE_MSK;
    end else if (cls_irq_wake) begin
      st_val = `RSI_ST_IWAKE_VAL;
      st_msk = `RSI_ST_WAKE_MSK;
    end
  end

  // Reset-cause flags: power-on clears bit 1, brown-out clears bit 0
  reg [7:0] pwr_msk;

  always @* begin
    pwr_msk = `RSI_ZERO;
    if (cls_por) begin
      pwr_msk = `RSI_PC_POR_MSK;
    end else if (cls_bor) begin
      pwr_msk = `RSI_PC_BOR_MSK;
    end
  end

  // Register write strobes
  wire wr_status;
  wire wr_pwr;
  wire wr_ictl;
  wire wr_pfa;
  wire wr_pfb;
  wire wr_opt;
  wire wr_dira;
  wire wr_per;

  assign wr_status = wr & (addr == `RSI_OFF_STATUS);
  assign wr_pwr    = wr & (addr == `RSI_OFF_PWR_CAUSE);
  assign wr_ictl   = wr & (addr == `RSI_OFF_IRQ_CTL);
  assign wr_pfa    = wr & (addr == `RSI_OFF_PFLAG_A);
  assign wr_pfb    = wr & (addr == `RSI_OFF_PFLAG_B);
  assign wr_opt    = wr & (addr == `RSI_OFF_OPTION);
  assign wr_dira   = wr & (addr == `RSI_OFF_DIR_A);
  assign wr_per    = wr & (addr == `RSI_OFF_PERIOD_B);

  // Wake flag sets
  wire [7:0] set_ictl;
  wire [7:0] set_pfa;
  wire [7:0] set_pfb;

  assign set_ictl = any_wake ? wake_src_ctl : `RSI_ZERO;
  assign set_pfa  = any_wake ? wake_src_a : `RSI_ZERO;
  assign set_pfb  = any_wake ? wake_src_b : `RSI_ZERO;

  wire [7:0] q_status;
  wire [7:0] q_pwr;
  wire [7:0] q_ictl;
  wire [7:0] q_pfa;
  wire [7:0] q_pfb;
  wire [7:0] q_opt;
  wire [7:0] q_dira;
  wire [7:0] q_per;

  rsi_sfr #(.INIT(`RSI_ST_POR_VAL), .IMPL(`RSI_IMPL_FULL), .WMASK(`RSI_ST_WMASK)) u_status (
    .clk (clk), .reset_n (reset_n), .load (any_rst | any_wake), .load_val (st_val),
    .load_mask (st_msk), .wr (wr_status), .wdata (wdata), .set_bits (`RSI_ZERO),
    .q (q_status)
  );

  rsi_sfr #(.INIT(`RSI_ZERO), .IMPL(`RSI_IMPL_PWR_CAUSE), .WMASK(`RSI_ONES)) u_pwr (
    .clk (clk), .reset_n (reset_n), .load (cls_por | cls_bor), .load_val (`RSI_ZERO),
    .load_mask (pwr_msk), .wr (wr_pwr), .wdata (wdata), .set_bits (`RSI_ZERO),
    .q (q_pwr)
  );

  // Interrupt control: bit 0 survives every class reset but is cleared by the system reset, global enable clears
  rsi_sfr #(.INIT(`RSI_ZERO), .IMPL(`RSI_IMPL_FULL), .WMASK(`RSI_ONES)) u_ictl (
    .clk (clk), .reset_n (reset_n), .load (any_rst), .load_val (`RSI_ZERO),
    .load_mask (`RSI_IC_RST_MSK), .wr (wr_ictl), .wdata (wdata), .set_bits (set_ictl),
    .q (q_ictl)
  );

  rsi_sfr #(.INIT(`RSI_ZERO), .IMPL(`RSI_IMPL_FULL), .WMASK(`RSI_ONES)) u_pfa (
    .clk (clk), .reset_n (reset_n), .load (any_rst), .load_val (`RSI_ZERO),
    .load_mask (`RSI_ONES), .wr (wr_pfa), .wdata (wdata), .set_bits (set_pfa),
    .q (q_pfa)
  );

  rsi_sfr #(.INIT(`RSI_ZERO), .IMPL(`RSI_IMPL_PFLAG_B), .WMASK(`RSI_ONES)) u_pfb (
    .clk (clk), .reset_n (reset_n), .load (any_rst), .load_val (`RSI_ZERO),
    .load_mask (`RSI_ONES), .wr (wr_pfb), .wdata (wdata), .set_bits (set_pfb),
    .q (q_pfb)
  );

  rsi_sfr #(.INIT(`RSI_ONES), .IMPL(`RSI_IMPL_FULL), .WMASK(`RSI_ONES)) u_opt (
    .clk (clk), .reset_n (reset_n), .load (any_rst), .load_val (`RSI_ONES),
    .load_mask (`RSI_ONES), .wr (wr_opt), .wdata (wdata), .set_bits (`RSI_ZERO),
    .q (q_opt)
  );

  rsi_sfr #(.INIT(`RSI_ONES), .IMPL(`RSI_IMPL_DIR_A), .WMASK(`RSI_ONES)) u_dira (
    .clk (clk), .reset_n (reset_n), .load (any_rst), .load_val (`RSI_ONES),
    .load_mask (`RSI_ONES), .wr (wr_dira), .wdata (wdata), .set_bits (`RSI_ZERO),
    .q (q_dira)
  );

  rsi_sfr #(.INIT(`RSI_ONES), .IMPL(`RSI_IMPL_FULL), .WMASK(`RSI_ONES)) u_per (
    .clk (clk), .reset_n (reset_n), .load (any_rst | any_wake), .load_val (`RSI_ONES),
    .load_mask (`RSI_ONES), .wr (wr_per), .wdata (wdata), .set_bits (`RSI_ZERO),
    .q (q_per)
  );

  // Scratch register that no reset touches, not even the system reset
  reg [7:0] hold_ff;

  always @(posedge clk) begin
    if (wr & (addr == `RSI_OFF_HOLD)) begin
      hold_ff <= wdata;
    end
  end

  // Program counter placement
  reg                nxt_pc_load;
  reg [`RSI_PCW-1:0] nxt_pc_value;

  always @* begin
    nxt_pc_load  = 1'b0;
    nxt_pc_value = pc_value_ff;
    if (any_rst) begin
      nxt_pc_load  = 1'b1;
      nxt_pc_value = `RSI_PC_RESET;
    end else if (cls_irq_wake & q_ictl[`RSI_GIE_BIT]) begin
      nxt_pc_load  = 1'b1;
      nxt_pc_value = `RSI_PC_VECTOR;
    end else if (any_wake) begin
      nxt_pc_load  = 1'b1;
      nxt_pc_value = core_pc + `RSI_PC_STEP;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_load_ff  <= 1'b0;
      pc_value_ff <= `RSI_PC_RESET;
    end else begin
      pc_load_ff  <= nxt_pc_load;
      pc_value_ff <= nxt_pc_value;
    end
  end

  // Class event flags, sticky with write-one-to-clear, set wins
  reg  [`RSI_EVW-1:0] ev_stat_ff;
  reg  [`RSI_EVW-1:0] ev_mask_ff;
  wire [`RSI_EVW-1:0] ev_now;
  wire [`RSI_EVW-1:0] ev_clr;
  wire [`RSI_EVW-1:0] nxt_ev_stat;
  wire [`RSI_EVW-1:0] nxt_ev_mask;

  assign ev_now = {cls_irq_wake, cls_wdt_wake, cls_wdt_rst, cls_master_clear_pin, cls_bor, cls_por};
  assign ev_clr = (wr & (addr == `RSI_OFF_EV_STAT)) ? wdata[`RSI_EVW-1:0] : {`RSI_EVW{1'b0}};
  assign nxt_ev_stat = (ev_stat_ff & ~ev_clr) | ev_now;
  // Interrupt level follows a mask written in the same cycle, not one cycle late
  assign nxt_ev_mask = (wr & (addr == `RSI_OFF_EV_MASK)) ? wdata[`RSI_EVW-1:0] : ev_mask_ff;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_stat_ff <= {`RSI_EVW{1'b0}};
      ev_mask_ff <= {`RSI_EVW{1'b0}};
      irq_ff     <= 1'b0;
      class_ff   <= {`RSI_EVW{1'b0}};
    end else begin
      ev_stat_ff <= nxt_ev_stat;
      if (wr & (addr == `RSI_OFF_EV_MASK)) begin
        ev_mask_ff <= wdata[`RSI_EVW-1:0];
      end
      irq_ff     <= |(nxt_ev_stat & nxt_ev_mask);
      class_ff   <= ev_now;
    end
  end

  // Read path, one cycle after the strobe; unmapped reads return zero
  reg [7:0] rd_mux;

  always @* begin
    case (addr)
      `RSI_OFF_STATUS:    rd_mux = q_status;
      `RSI_OFF_PWR_CAUSE: rd_mux = q_pwr;
      `RSI_OFF_IRQ_CTL:   rd_mux = q_ictl;
      `RSI_OFF_PFLAG_A:   rd_mux = q_pfa;
      `RSI_OFF_PFLAG_B:   rd_mux = q_pfb;
      `RSI_OFF_OPTION:    rd_mux = q_opt;
      `RSI_OFF_DIR_A:     rd_mux = q_dira;
      `RSI_OFF_PERIOD_B:  rd_mux = q_per;
      `RSI_OFF_HOLD:      rd_mux = hold_ff;
      `RSI_OFF_EV_STAT:   rd_mux = {2'b00, ev_stat_ff};
      `RSI_OFF_EV_MASK:   rd_mux = {2'b00, ev_mask_ff};
      default:            rd_mux = `RSI_ZERO;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= `RSI_ZERO;
    end else if (rd) begin
      rdata_ff <= rd_mux;
    end else begin
      rdata_ff <= `RSI_ZERO;
    end
  end

endmodule

// [test/rsi_top_sva.sv]
// Port-level assertions for the reset state initializer
`timescale 1ns/1ps
`include "rsi_defines.vh"
module rsi_top_sva (
  input wire        clk,
  input wire        reset_n,
  input wire        por_pulse,
  input wire        master_clear_pin_n,
  input wire        wake_irq,
  input wire        core_sleeping,
  input wire [12:0] core_pc,
  input wire [3:0]  addr,
  input wire        rd,
  input wire [7:0]  rdata_ff,
  input wire        pc_load_ff,
  input wire [12:0] pc_value_ff,
  input wire [5:0]  class_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_rd_idle: assert property (!$past(rd) |-> rdata_ff == 8'h00)
    else $error("read data not zero outside a read");
  chk_cause_unimpl: assert property ($past(rd) && $past(addr) == `RSI_OFF_PWR_CAUSE
    |-> rdata_ff[7:2] == 6'h00) else $error("power cause upper bits not zero");
  chk_flagb_unimpl: assert property ($past(rd) && $past(addr) == `RSI_OFF_PFLAG_B
    |-> rdata_ff[7:1] == 7'h00) else $error("flag B upper bits not zero");
  chk_unmapped_zero: assert property ($past(rd) && $past(addr) > `RSI_OFF_EV_MASK
    |-> rdata_ff == 8'h00) else $error("unmapped read not zero");
  chk_reset_pc: assert property (class_ff[3:0] != 4'h0 |-> pc_value_ff == 13'h0000)
    else $error("reset class did not place PC at zero");
  chk_wake_pc: assert property (class_ff[4] |-> pc_value_ff == $past(core_pc) + 13'h0001)
    else $error("watchdog wake did not place PC plus one");
  chk_class_pulse: assert property (class_ff != 6'h00 |-> $onehot(class_ff) && pc_load_ff)
    else $error("class not one-hot or PC load missing");
  chk_pc_hold: assert property (!pc_load_ff |-> $stable(pc_value_ff))
    else $error("PC value changed without a load");
  chk_por_class: assert property ($rose(por_pulse) |-> ##[1:4] class_ff[0])
    else $error("power-on class not decoded");
  chk_master_clear_pin_class: assert property ($fell(master_clear_pin_n) |-> ##[1:4] class_ff[2])
    else $error("master clear class not decoded");
  chk_irq_wake: assert property ($rose(wake_irq) && core_sleeping |-> ##[1:4] class_ff[5])
    else $error("interrupt wake not decoded");
endmodule
bind rsi_top rsi_top_sva i_chk (
  .clk(clk),
  .reset_n(reset_n),
  .por_pulse(por_pulse),
  .master_clear_pin_n(master_clear_pin_n),
  .wake_irq(wake_irq),
  .core_sleeping(core_sleeping),
  .core_pc(core_pc),
  .addr(addr),
  .rd(rd),
  .rdata_ff(rdata_ff),
  .pc_load_ff(pc_load_ff),
  .pc_value_ff(pc_value_ff),
  .class_ff(class_ff)
);

// [test/tb.sv]
// Self-checking bench for the reset state initializer
`timescale 1ns/1ps
`include "rsi_defines.vh"
module tb;
  reg         clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         por_pulse = 1'b0;
  reg         brownout_pulse = 1'b0;
  reg         master_clear_pin_n = 1'b1;
  reg         watchdog_timer_timeout = 1'b0;
  reg         wake_irq = 1'b0;
  reg         core_sleeping = 1'b0;
  reg  [12:0] core_pc = 13'h0123;
  reg  [7:0]  wake_src_ctl = 8'h00;
  reg  [7:0]  wake_src_a = 8'h00;
  reg  [7:0]  wake_src_b = 8'h00;
  reg  [3:0]  addr = 4'h0;
  reg  [7:0]  wdata = 8'h00;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  wire [7:0]  rdata_ff;
  wire        irq_ff;
  wire        pc_load_ff;
  wire [12:0] pc_value_ff;
  wire [5:0]  class_ff;
  integer     fails = 0;
  integer     comparisons = 0;
  always #4 clk = ~clk;
  rsi_top i_dut (
    .clk(clk),
    .reset_n(reset_n),
    .por_pulse(por_pulse),
    .brownout_pulse(brownout_pulse),
    .master_clear_pin_n(master_clear_pin_n),
    .watchdog_timer_timeout(watchdog_timer_timeout),
    .wake_irq(wake_irq),
    .core_sleeping(core_sleeping),
    .core_pc(core_pc),
    .wake_src_ctl(wake_src_ctl),
    .wake_src_a(wake_src_a),
    .wake_src_b(wake_src_b),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata_ff(rdata_ff),
    .irq_ff(irq_ff),
    .pc_load_ff(pc_load_ff),
    .pc_value_ff(pc_value_ff),
    .class_ff(class_ff)
  );
  task chk(input string n, input [12:0] s, input [12:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("[ERR] %s exp %h got %h", n, e, s);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
    end
  endtask
  task rd_chk(input [3:0] a, input [7:0] e);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), {5'h00, rdata_ff}, {5'h00, e});
    end
  endtask
  // Holds one source active long enough to pass the synchroniser, then settles
  task ev(input [2:0] k);
    begin
      @(posedge clk);
      case (k)
        3'h0: por_pulse <= 1'b1;
        3'h1: brownout_pulse <= 1'b1;
        3'h2: master_clear_pin_n <= 1'b0;
        3'h3: watchdog_timer_timeout <= 1'b1;
        default: wake_irq <= 1'b1;
      endcase
      repeat (6) @(posedge clk);
      por_pulse <= 1'b0;
      brownout_pulse <= 1'b0;
      master_clear_pin_n <= 1'b1;
      watchdog_timer_timeout <= 1'b0;
      wake_irq <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #40000;
    fails = fails + 1;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`RSI_OFF_STATUS, 8'h18);
    rd_chk(`RSI_OFF_OPTION, 8'hFF);
    rd_chk(`RSI_OFF_DIR_A, 8'h3F);
    rd_chk(`RSI_OFF_PERIOD_B, 8'hFF);
    wr_reg(`RSI_OFF_PWR_CAUSE, 8'hFF);
    wr_reg(`RSI_OFF_PFLAG_B, 8'hFF);
    wr_reg(`RSI_OFF_DIR_A, 8'hFF);
    wr_reg(4'hF, 8'h77);
    rd_chk(`RSI_OFF_PWR_CAUSE, 8'h03);
    rd_chk(`RSI_OFF_PFLAG_B, 8'h01);
    rd_chk(`RSI_OFF_DIR_A, 8'h3F);
    rd_chk(4'hF, 8'h00);
    wr_reg(`RSI_OFF_HOLD, 8'h5A);
    wr_reg(`RSI_OFF_OPTION, 8'h00);
    ev(3'h1);
    rd_chk(`RSI_OFF_PWR_CAUSE, 8'h02);
    rd_chk(`RSI_OFF_OPTION, 8'hFF);
    rd_chk(`RSI_OFF_STATUS, 8'h18);
    wr_reg(`RSI_OFF_PWR_CAUSE, 8'h03);
    ev(3'h0);
    rd_chk(`RSI_OFF_PWR_CAUSE, 8'h01);
    rd_chk(`RSI_OFF_HOLD, 8'h5A);
    wr_reg(`RSI_OFF_STATUS, 8'hFF);
    ev(3'h2);
    rd_chk(`RSI_OFF_STATUS, 8'h1F);
    rd_chk(`RSI_OFF_PWR_CAUSE, 8'h01);
    ev(3'h3);
    rd_chk(`RSI_OFF_STATUS, 8'h0F);
    @(posedge clk);
    core_sleeping <= 1'b1;
    ev(3'h2);
    rd_chk(`RSI_OFF_STATUS, 8'h17);
    wr_reg(`RSI_OFF_OPTION, 8'h00);
    wr_reg(`RSI_OFF_PERIOD_B, 8'h00);
    @(posedge clk);
    wake_src_a <= 8'h24;
    ev(3'h3);
    rd_chk(`RSI_OFF_STATUS, 8'h07);
    rd_chk(`RSI_OFF_PERIOD_B, 8'hFF);
    rd_chk(`RSI_OFF_OPTION, 8'h00);
    rd_chk(`RSI_OFF_PFLAG_A, 8'h24);
    chk("pc", pc_value_ff, 13'h0124);
    rd_chk(`RSI_OFF_HOLD, 8'h5A);
    wr_reg(`RSI_OFF_IRQ_CTL, 8'h80);
    @(posedge clk);
    wake_src_ctl <= 8'h02;
    wake_src_b <= 8'h01;
    ev(3'h4);
    rd_chk(`RSI_OFF_STATUS, 8'h17);
    rd_chk(`RSI_OFF_IRQ_CTL, 8'h82);
    rd_chk(`RSI_OFF_PFLAG_B, 8'h01);
    rd_chk(`RSI_OFF_PFLAG_A, 8'h24);
    chk("pc", pc_value_ff, 13'h0004);
    wr_reg(`RSI_OFF_IRQ_CTL, 8'h00);
    ev(3'h4);
    chk("pc", pc_value_ff, 13'h0124);
    rd_chk(`RSI_OFF_IRQ_CTL, 8'h02);
    rd_chk(`RSI_OFF_EV_STAT, 8'h3F);
    chk("irq", {12'h000, irq_ff}, 13'h0000);
    wr_reg(`RSI_OFF_EV_MASK, 8'h20);
    chk("irq", {12'h000, irq_ff}, 13'h0001);
    wr_reg(`RSI_OFF_EV_STAT, 8'h20);
    chk("irq", {12'h000, irq_ff}, 13'h0000);
    rd_chk(`RSI_OFF_EV_STAT, 8'h1F);
    // An interrupt while awake is no wake-up: no class, no PC placement
    @(posedge clk);
    core_sleeping <= 1'b0;
    ev(3'h4);
    rd_chk(`RSI_OFF_EV_STAT, 8'h1F);
    chk("pc", pc_value_ff, 13'h0124);
    chk("irq", {12'h000, irq_ff}, 13'h0000);
    wrap_up;
  end
endmodule
